// file: src/memory_map_write_protect.sv
// address decoder, sram, rom port and guarded control registers
//
// Functional notes
// [R01] 0000h-007Fh decodes to 128-byte sram
// [R02] 0100h-017Fh mirrors the same sram bytes
// [R03] 00B0h-00FFh goes to special function registers
// [R04] E000h-FFFFh decodes to 8K program rom
// [R05] registers take whole-byte accesses only
// [R06] software writes 78h to key first
// [R07] guard wdt flag, clock/halt bits, clock select
// [R08] key clears after the next write
// [R09] guarded write dropped unless key matches
`timescale 1ns/1ns
`default_nettype none
`include "memory_map_params.svh"
module memory_map_write_protect
  import memory_map_pkg::*;
#(
  parameter int SRAM_DEPTH = `SRAM_DEPTH,
  parameter int ROM_DEPTH  = `ROM_DEPTH
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [7:0]  rom_data_i,
  input  wire logic [7:0]  sfr_rdata_i,
  input  wire logic        wdt_event_i,
  input  wire logic        lvd_event_i,
  output logic      [7:0]  rdata_o,
  output logic      [12:0] rom_addr_o,
  output logic      [7:0]  sfr_addr_o,
  output logic             sfr_wr_o,
  output logic             sfr_rd_o,
  output logic      [7:0]  sfr_wdata_o,
  output logic      [7:0]  system_status_reg_o,
  output logic      [7:0]  power_control_reg_o,
  output logic      [7:0]  clock_select_reg_o,
  output logic             unlocked_o
);
  initial
  begin
    if (SRAM_DEPTH != 128 || ROM_DEPTH != 8192)
      $error("memory map widths are fixed at 128 bytes ram, 8K rom");
  end

  ////////////////////////////////////////////////////////////////////////
  // decode
  wire hit_sram   = addr_i <= `SRAM_LAST;                        // R01
  wire hit_mirror = addr_i >= `SRAM_MIRROR_BASE &&
                    addr_i <= `SRAM_MIRROR_LAST;                 // R02
  wire hit_sfr    = addr_i >= `SFR_BASE && addr_i <= `SFR_LAST;  // R03
  wire hit_rom    = addr_i >= `ROM_BASE;                         // R04
  wire hit_ram    = hit_sram || hit_mirror;
  region_e region;
  assign region = hit_ram ? REGION_SRAM :
                  hit_sfr ? REGION_SFR  :
                  hit_rom ? REGION_ROM  : REGION_NONE;

  // mirror drops bit 8, so both windows share one byte index
  wire [6:0] ram_index = addr_i[6:0];                            // R02
  wire       ram_we    = ce_i && wr_i && hit_ram;

  // a bus write is always one full byte; there is no bit-write path
  wire wr_go      = ce_i && wr_i;                                // R05
  wire wr_key     = wr_go && addr_i == `ADDR_UNLOCK_KEY;
  wire wr_sys     = wr_go && addr_i == `ADDR_SYS_STATUS;
  wire wr_pwr     = wr_go && addr_i == `ADDR_POWER_CTRL;
  wire wr_sck     = wr_go && addr_i == `ADDR_CLOCK_SEL;
  wire own_reg    = addr_i == `ADDR_UNLOCK_KEY ||
                    addr_i == `ADDR_SYS_STATUS ||
                    addr_i == `ADDR_POWER_CTRL ||
                    addr_i == `ADDR_CLOCK_SEL;
  logic [7:0] unlock_key;
  wire key_ok     = unlock_key == `UNLOCK_PATTERN;               // R09

  ////////////////////////////////////////////////////////////////////////
  // guarded registers
  logic [7:0] next_unlock_key;
  logic       wdt_flag;
  logic       next_wdt_flag;
  logic       lvd_flag;
  logic       next_lvd_flag;
  logic [7:0] next_pwr;
  logic [7:0] next_sck;

  // any write other than to the key itself spends the unlock
  assign next_unlock_key = wr_key ? wdata_i :
                           wr_go  ? `UNLOCK_RESET : unlock_key;  // R08

  // hardware set wins over a clear in the same cycle
  assign next_wdt_flag = wdt_event_i ? 1'b1 :
                         (wr_sys && key_ok && wdata_i[`SYS_WDT_BIT])
                         ? 1'b0 : wdt_flag;                      // R07 R09
  assign next_lvd_flag = lvd_event_i ? 1'b1 :
                         (wr_sys && wdata_i[`SYS_LVD_BIT])
                         ? 1'b0 : lvd_flag;

  // unguarded power bits always update; guarded ones need the key
  assign next_pwr = !wr_pwr ? power_control_reg_o :
                    ((wdata_i & `PWR_WR_MASK) |
                     ((key_ok ? wdata_i : power_control_reg_o)
                      & `PWR_PROT_MASK));                        // R07 R09
  assign next_sck = (wr_sck && key_ok) ? (wdata_i & `SCK_WR_MASK)
                                       : clock_select_reg_o;     // R07 R09

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      unlock_key          <= `UNLOCK_RESET;
      wdt_flag            <= 1'b0;
      lvd_flag            <= 1'b0;
      power_control_reg_o <= `PWR_RESET;
      clock_select_reg_o  <= `SCK_RESET;
      unlocked_o          <= 1'b0;
    end
    else if (ce_i)
    begin
      unlock_key          <= next_unlock_key;
      wdt_flag            <= next_wdt_flag;
      lvd_flag            <= next_lvd_flag;
      power_control_reg_o <= next_pwr;
      clock_select_reg_o  <= next_sck;
      // registered copy of the key compare, so the pin never glitches
      unlocked_o          <= next_unlock_key == `UNLOCK_PATTERN;
    end
  end

  assign system_status_reg_o = {wdt_flag, 6'b00_0000, lvd_flag};

  ////////////////////////////////////////////////////////////////////////
  // storage and read path
  logic [7:0] ram_rdata;
  sram_bank #(
    .DEPTH (SRAM_DEPTH),
    .AW    (7)
  ) u_ram (
    .clk_sys_i (clk_sys_i),
    .ce_i      (ce_i),
    .we_i      (ram_we),
    .addr_i    (ram_index),
    .wdata_i   (wdata_i),
    .rdata_o   (ram_rdata)
  );

  region_e    rd_region;
  logic       rd_own;
  logic [7:0] own_rdata;
  // key and control registers are write only; status reads back
  wire [7:0] own_mux = (addr_i == `ADDR_SYS_STATUS) ?
                       system_status_reg_o : 8'h00;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      rd_region  <= REGION_NONE;
      rd_own     <= 1'b0;
      own_rdata  <= 8'h00;
      rom_addr_o <= 13'h0000;
      sfr_addr_o <= 8'h00;
      sfr_wr_o   <= 1'b0;
      sfr_rd_o   <= 1'b0;
      sfr_wdata_o <= 8'h00;
    end
    else if (ce_i)
    begin
      rd_region   <= rd_i ? region : REGION_NONE;
      rd_own      <= own_reg;
      own_rdata   <= own_mux;
      rom_addr_o  <= addr_i[12:0];                               // R04
      sfr_addr_o  <= addr_i[7:0];                                // R03
      sfr_wr_o    <= wr_i && hit_sfr && !own_reg;                // R03
      sfr_rd_o    <= rd_i && hit_sfr && !own_reg;
      sfr_wdata_o <= wdata_i;
    end
  end

  // rom and sfr peripherals answer in the same cycle as their registered strobe
  wire [7:0] sfr_read = rd_own ? own_rdata : sfr_rdata_i;
  assign rdata_o = (rd_region == REGION_SRAM) ? ram_rdata  :
                   (rd_region == REGION_SFR)  ? sfr_read   :
                   (rd_region == REGION_ROM)  ? rom_data_i : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_key_spent: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && wr_i && !wr_key |=> unlock_key == `UNLOCK_RESET)  // R08
    else $error("unlock key not cleared after write");
  a_sck_guard: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && wr_sck && !key_ok |=> $stable(clock_select_reg_o))  // R09
    else $error("clock select changed while locked");
  a_pwr_guard: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && wr_pwr && !key_ok
    |=> power_control_reg_o[2:0] == $past(power_control_reg_o[2:0]))  // R07
    else $error("guarded power bits changed while locked");
  a_wdt_guard: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wdt_flag && !wdt_event_i && !(ce_i && wr_sys && key_ok)
    |=> wdt_flag)  // R07
    else $error("wdt flag cleared without unlock");
  a_mirror_map: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    hit_mirror |-> region == REGION_SRAM && ram_index == addr_i[6:0])  // R02
    else $error("mirror not mapped onto sram");
  a_sfr_strobe: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && wr_i && hit_sfr && !own_reg |=> sfr_wr_o)  // R03
    else $error("sfr write strobe missing");
  a_rom_addr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ce_i && rd_i && hit_rom |=> rd_region == REGION_ROM &&
    rom_addr_o == $past(addr_i[12:0]))  // R04
    else $error("rom read misrouted");
  a_sram_low: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    addr_i[15:7] == 9'h000 |-> region == REGION_SRAM)  // R01
    else $error("low page not sram");

  // unlock, one quiet cycle, then a guarded power write that must land
  sequence s_key_loaded;
    ce_i && wr_key && wdata_i == `UNLOCK_PATTERN;
  endsequence
  sequence s_bus_quiet;
    !wr_i;
  endsequence
  sequence s_pwr_write;
    ce_i && wr_pwr;
  endsequence
  a_unlock_pwr: assert property (  // R07
    @(posedge clk_sys_i) disable iff (rst_i)
    s_key_loaded ##1 s_bus_quiet ##1 s_pwr_write
    |=> power_control_reg_o[2:0] == $past(wdata_i[2:0]))
    else $error("unlocked power write did not land");
endmodule
`default_nettype wire

// file: src/memory_map_params.svh
// address map, field positions and reset values of the memory map block
`ifndef MEMORY_MAP_PARAMS_SVH
`define MEMORY_MAP_PARAMS_SVH
`define SRAM_BASE        16'h0000
`define SRAM_LAST        16'h007F
`define SRAM_MIRROR_BASE 16'h0100
`define SRAM_MIRROR_LAST 16'h017F
`define SFR_BASE         16'h00B0
`define SFR_LAST         16'h00FF
`define ROM_BASE         16'hE000
`define ROM_LAST         16'hFFFF
`define SRAM_DEPTH       128
`define ROM_DEPTH        8192
`define ADDR_UNLOCK_KEY  16'h00FA
`define ADDR_SYS_STATUS  16'h00B7
`define ADDR_POWER_CTRL  16'h00BC
`define ADDR_CLOCK_SEL   16'h00BA
`define UNLOCK_PATTERN   8'h78
`define UNLOCK_RESET     8'h00
`define SYS_WDT_BIT      7
`define SYS_LVD_BIT      0
`define PWR_PROT_MASK    8'h07
`define PWR_WR_MASK      8'h50
`define SCK_WR_MASK      8'h9D
`define PWR_RESET        8'h00
`define SCK_RESET        8'h00
`endif

// file: src/memory_map_pkg.sv
// types shared by the memory map block
package memory_map_pkg;
  typedef enum logic [1:0] {
    REGION_NONE = 2'b00,
    REGION_SRAM = 2'b01,
    REGION_SFR  = 2'b10,
    REGION_ROM  = 2'b11
  } region_e;
endpackage

// file: src/sram_bank.sv
// byte-wide flip-flop storage used for data ram
`timescale 1ns/1ns
`default_nettype none
module sram_bank #(
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  input  wire logic          clk_sys_i,
  input  wire logic          ce_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [7:0]    wdata_i,
  output var  logic [7:0]    rdata_o
);
  logic [7:0] mem [DEPTH];

  initial
  begin
    if (DEPTH > (1 << AW))
      $error("sram_bank depth does not fit address width");
  end

  // contents are not reset: data ram keeps its value over a pin reset
  always_ff @(posedge clk_sys_i)
  begin
    if (ce_i && we_i)
      mem[addr_i] <= wdata_i;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (ce_i)
      rdata_o <= mem[addr_i];
  end
endmodule
`default_nettype wire

// file: tb/cpu_bus_model.sv
// cpu side model: byte bus requests and rom contents
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_model (
  input  wire logic        clk_sys_i,
  input  wire logic [12:0] rom_addr_i,
  output var  logic [15:0] addr_o,
  output var  logic        rd_o,
  output var  logic        wr_o,
  output var  logic [7:0]  wdata_o,
  output logic      [7:0]  rom_data_o
);
  assign rom_data_o = rom_addr_i[7:0] ^ 8'h5a;
  initial
  begin
    addr_o  = 16'h0000;
    rd_o    = 1'b0;
    wr_o    = 1'b0;
    wdata_o = 8'h00;
  end
  // one whole byte per request, never a bit operation
  // unlock is sent as a plain 78h byte write by callers
  task automatic access(input logic w, input logic [15:0] a,
                        input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= w;
    rd_o    <= !w;
    @(posedge clk_sys_i);
    wr_o    <= 1'b0;
    rd_o    <= 1'b0;
    // released data lines must not keep the last byte
    wdata_o <= ~d;
    #1;
  endtask
endmodule
`default_nettype wire

// file: tb/memory_map_write_protect_bench.sv
// self-checking bench for the memory map and write guard
`timescale 1ns/1ns
`default_nettype none
module memory_map_write_protect_bench;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wdt_event = 1'b0;
  logic        lvd_event = 1'b0;
  logic        ce = 1'b1;
  logic [15:0] addr;
  logic        rd, wr, sfr_wr, sfr_rd, unlocked;
  logic [7:0]  wdata, rom_data, rdata, sfr_addr, sfr_wdata;
  logic [7:0]  system_status_reg, pwr, sck;
  logic [12:0] rom_addr;
  int          error_cnt = 0;
  int          samples_checked = 0;
  initial
  begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  cpu_bus_model u_cpu_bus_model (.clk_sys_i(clk_sys_i),
    .rom_addr_i(rom_addr), .addr_o(addr), .rd_o(rd), .wr_o(wr),
    .wdata_o(wdata), .rom_data_o(rom_data));
  memory_map_write_protect u_memory_map_write_protect (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce), .addr_i(addr),
    .rd_i(rd), .wr_i(wr), .wdata_i(wdata), .rom_data_i(rom_data),
    .sfr_rdata_i(8'hc6), .wdt_event_i(wdt_event),
    .lvd_event_i(lvd_event), .rdata_o(rdata), .rom_addr_o(rom_addr),
    .sfr_addr_o(sfr_addr), .sfr_wr_o(sfr_wr), .sfr_rd_o(sfr_rd),
    .sfr_wdata_o(sfr_wdata), .system_status_reg_o(system_status_reg),
    .power_control_reg_o(pwr), .clock_select_reg_o(sck),
    .unlocked_o(unlocked));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [7:0] d);
    u_cpu_bus_model.access(w, a, d);
  endtask
  task automatic t_ram();
    acc(1, 16'h0005, 8'ha5);
    acc(0, 16'h0105, 8'h00);
    chk("ram mirror", 16'h00a5, {8'h00, rdata});
    acc(1, 16'h017f, 8'h3c);
    acc(0, 16'h007f, 8'h00);
    chk("ram top", 16'h003c, {8'h00, rdata});
    $display("test ram done");
  endtask
  task automatic t_rom_sfr();
    acc(0, 16'he123, 8'h00);
    chk("rom data", 16'h0079, {8'h00, rdata});
    acc(1, 16'h00c3, 8'h11);
    chk("sfr write strobe", 16'h0001, {15'h0000, sfr_wr});
    chk("sfr write byte", 16'hc311, {sfr_addr, sfr_wdata});
    acc(0, 16'h00ff, 8'h00);
    chk("sfr read", 16'h01c6, {sfr_rd, rdata});
    acc(1, 16'h0080, 8'h22);
    chk("gap write", 16'h0000, {15'h0000, sfr_wr});
    $display("test rom and sfr done");
  endtask
  task automatic t_guard();
    acc(1, 16'h00ba, 8'h9d);
    chk("locked sck", 16'h0000, {8'h00, sck});
    acc(1, 16'h00fa, 8'h78);
    chk("unlocked", 16'h0001, {15'h0000, unlocked});
    acc(0, 16'h00fa, 8'h00);
    chk("key read", 16'h0000, {8'h00, rdata});
    acc(1, 16'h00ba, 8'h9d);
    chk("open sck", 16'h009d, {7'h00, unlocked, sck});
    acc(1, 16'h00fa, 8'h78);
    acc(1, 16'h00c3, 8'h00);
    acc(1, 16'h00bc, 8'hff);
    chk("spent key", 16'h0050, {8'h00, pwr});
    acc(1, 16'h00fa, 8'h78);
    acc(1, 16'h00bc, 8'hff);
    chk("open pwr", 16'h0057, {8'h00, pwr});
    @(posedge clk_sys_i);
    wdt_event <= 1'b1;
    lvd_event <= 1'b1;
    @(posedge clk_sys_i);
    wdt_event <= 1'b0;
    lvd_event <= 1'b0;
    acc(1, 16'h00b7, 8'h81);
    chk("locked wdt", 16'h0080, {8'h00, system_status_reg});
    acc(1, 16'h00fa, 8'h78);
    acc(1, 16'h00b7, 8'h80);
    chk("open wdt", 16'h0000, {8'h00, system_status_reg});
    // watchdog event held across an unlocked clear: the set must win
    @(posedge clk_sys_i);
    wdt_event <= 1'b1;
    acc(1, 16'h00fa, 8'h78);
    acc(1, 16'h00b7, 8'h80);
    chk("wdt set wins", 16'h0080, {8'h00, system_status_reg});
    @(posedge clk_sys_i);
    wdt_event <= 1'b0;
    $display("test guard done");
  endtask
  task automatic t_freeze();
    acc(1, 16'h0010, 8'h11);
    @(posedge clk_sys_i);
    ce <= 1'b0;
    acc(1, 16'h0010, 8'h99);
    acc(1, 16'h00fa, 8'h78);
    chk("frozen key", 16'h0000, {15'h0000, unlocked});
    @(posedge clk_sys_i);
    ce <= 1'b1;
    acc(0, 16'h0110, 8'h00);
    chk("frozen ram", 16'h0011, {8'h00, rdata});
    $display("test freeze done");
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_ram();
    t_rom_sfr();
    t_guard();
    t_freeze();
    stop_test();
  end
  initial
  begin
    #20000;
    error_cnt++;
    stop_test();
  end
endmodule
`default_nettype wire
